// >>> hdl/fault_flag_bank_defs.svh
// offsets, field positions, reset values and counts of the fault flag bank
`ifndef FAULT_FLAG_BANK_DEFS_SVH
`define FAULT_FLAG_BANK_DEFS_SVH

// ****************************************
// register addresses
// ****************************************
`define FFB_ADDR_FLAGS 6'h06
`define FFB_ADDR_ENABLES 6'h07
`define FFB_ADDR_TICKS 6'h3D

// ****************************************
// fault flag bits and enable bits
// ****************************************
`define FFB_BIT_ROM_CRC 0
`define FFB_BIT_CFG_CRC 1
`define FFB_BIT_LINK_CRC 2
`define FFB_BIT_BAD_WRITE 3
`define FFB_BIT_BAD_READ 4
`define FFB_BIT_NEG_RANGE_ON 10
`define FFB_BIT_POS_RANGE_ON 11
`define FFB_BIT_TICK_CNT_ON 12

// ****************************************
// reset values, masks, crc constants and check period
// ****************************************
`define FFB_ENABLES_RESET 16'h0040
`define FFB_ENABLES_WMASK 16'h1FFF
`define FFB_FLAGS_RESET 16'h0000
`define FFB_FLAGS_IMPL 16'h001F
`define FFB_CRC_POLY 8'h07
`define FFB_CRC_SEED 8'hFF
`define FFB_CHECK_PERIOD 1000

`endif

// >>> hdl/fault_flag_bank_pkg.sv
// types shared by the fault flag bank
`default_nettype none

package fault_flag_bank_pkg;

    // one register access handed over by the serial frame decoder
    typedef struct packed {
        logic rd;
        logic wr;
        logic bad_addr;
        logic [5:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [0:0] {
        ST_ROM_CHECK,
        ST_RUN
    } bank_state_t;

endpackage : fault_flag_bank_pkg

`default_nettype wire

// >>> hdl/fault_flag_bank.sv
// fault flags, fault enables and master tick counter of the serial register interface
`timescale 1ns/1ns
`default_nettype none
`include "fault_flag_bank_defs.svh"

module fault_flag_bank #(
    parameter int CFG_W = 64,
    parameter int TICK_W = 16,
    parameter int CHECK_PERIOD = `FFB_CHECK_PERIOD,
    parameter logic [7:0] ROM_CRC_REF = 8'h00
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire fault_flag_bank_pkg::reg_req_t req,
    input wire logic link_crc_bad,
    input wire logic [CFG_W-1:0] cfg_image,
    input wire logic [CFG_W-1:0] rom_image,
    output logic [15:0] rd_data,
    output logic [15:0] fault_flags,
    output logic [15:0] fault_flag_enables,
    output logic pos_input_range_fault_on,
    output logic neg_input_range_fault_on,
    output logic master_tick_counter_on
);

    // refused at elaboration: the crc needs a full byte and the counter fits one register
    if (CFG_W < 8 || TICK_W < 1 || TICK_W > 16 || CHECK_PERIOD < 2) begin : g_bad_params
        $error("fault_flag_bank: unsupported parameter values");
    end

    // ****************************************
    // crc helper
    // ****************************************
    function automatic logic [7:0] crc8(input logic [CFG_W-1:0] data);
        logic [7:0] c;
        c = `FFB_CRC_SEED;
        for (int i = CFG_W - 1; i >= 0; i--) begin
            c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ `FFB_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    // ****************************************
    // state
    // ****************************************
    localparam int PER_W = $clog2(CHECK_PERIOD);
    localparam logic [PER_W-1:0] PER_LAST = PER_W'(CHECK_PERIOD - 1);

    fault_flag_bank_pkg::bank_state_t state_r;
    logic [15:0] flags_r, flags_nxt, en_r, rd_data_r;
    logic [TICK_W-1:0] ticks_r;
    logic [PER_W-1:0] per_r;
    logic [7:0] cfg_ref_r;
    logic cfg_ref_ok_r, cfg_dirty_r, rom_bad_r, rom_en_d_r;

    // ****************************************
    // decode
    // ****************************************
    wire logic hit_flags = req.addr == `FFB_ADDR_FLAGS;
    wire logic hit_en = req.addr == `FFB_ADDR_ENABLES;
    wire logic hit_ticks = req.addr == `FFB_ADDR_TICKS;
    wire logic wr_ok = req.wr && !req.bad_addr;
    wire logic clr_flags = wr_ok && hit_flags;
    wire logic wr_en = wr_ok && hit_en;
    wire logic per_tick = per_r == PER_LAST;
    wire logic cfg_chk_on = en_r[`FFB_BIT_CFG_CRC];
    wire logic [7:0] cfg_crc = crc8(cfg_image);
    // a write landing on the check cycle counts as a host change, never a fault
    wire logic cfg_dirty = cfg_dirty_r || wr_ok;
    wire logic rom_chk = state_r == fault_flag_bank_pkg::ST_ROM_CHECK;
    wire logic rom_bad_now = crc8(rom_image) != ROM_CRC_REF;
    // the ROM result is kept, so enabling the flag later still reports it
    wire logic rom_en_rise = en_r[`FFB_BIT_ROM_CRC] && !rom_en_d_r;
    wire logic [15:0] rd_mux = hit_flags ? flags_r :
                               hit_en ? en_r :
                               hit_ticks ? 16'(ticks_r) : 16'h0000;

    // ****************************************
    // fault events
    // ****************************************
    logic [15:0] evt;
    always_comb begin
        evt = 16'h0000;
        evt[`FFB_BIT_BAD_READ] = req.rd && req.bad_addr;
        evt[`FFB_BIT_BAD_WRITE] = req.wr && req.bad_addr;
        evt[`FFB_BIT_LINK_CRC] = link_crc_bad;
        evt[`FFB_BIT_CFG_CRC] = per_tick && cfg_chk_on && cfg_ref_ok_r && !cfg_dirty
                                && cfg_crc != cfg_ref_r;
        evt[`FFB_BIT_ROM_CRC] = (rom_chk && rom_bad_now) || (rom_en_rise && rom_bad_r);
    end

    // set wins over a same-cycle clear; enables gate the set
    always_comb begin
        flags_nxt = flags_r & ~(clr_flags ? req.wdata : 16'h0000);
        flags_nxt = (flags_nxt | (evt & en_r)) & `FFB_FLAGS_IMPL;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= fault_flag_bank_pkg::ST_ROM_CHECK;
            flags_r <= `FFB_FLAGS_RESET;
            en_r <= `FFB_ENABLES_RESET;
            rd_data_r <= 16'h0000;
            rom_bad_r <= 1'b0;
            rom_en_d_r <= 1'b0;
        end else begin
            state_r <= fault_flag_bank_pkg::ST_RUN;
            flags_r <= flags_nxt;
            if (wr_en) begin
                en_r <= req.wdata & `FFB_ENABLES_WMASK;
            end
            if (req.rd) begin
                rd_data_r <= req.bad_addr ? 16'h0000 : rd_mux;
            end
            if (rom_chk) begin
                rom_bad_r <= rom_bad_now;
            end
            rom_en_d_r <= en_r[`FFB_BIT_ROM_CRC];
        end
    end

    // counter only advances while enabled and holds its value when stopped
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ticks_r <= '0;
        end else if (en_r[`FFB_BIT_TICK_CNT_ON]) begin
            ticks_r <= ticks_r + TICK_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            per_r <= '0;
            cfg_ref_r <= 8'h00;
            cfg_ref_ok_r <= 1'b0;
            cfg_dirty_r <= 1'b0;
        end else if (!cfg_chk_on) begin
            per_r <= '0;
            cfg_ref_ok_r <= 1'b0;
            cfg_dirty_r <= 1'b0;
        end else if (per_tick) begin
            per_r <= '0;
            cfg_ref_r <= cfg_crc;
            cfg_ref_ok_r <= 1'b1;
            // a write on the check cycle lands after the sample, so it excuses the next check
            cfg_dirty_r <= wr_ok;
        end else begin
            per_r <= per_r + PER_W'(1);
            cfg_dirty_r <= cfg_dirty;
        end
    end

    assign rd_data = rd_data_r;
    assign fault_flags = flags_r;
    assign fault_flag_enables = en_r;
    assign pos_input_range_fault_on = en_r[`FFB_BIT_POS_RANGE_ON];
    assign neg_input_range_fault_on = en_r[`FFB_BIT_NEG_RANGE_ON];
    assign master_tick_counter_on = en_r[`FFB_BIT_TICK_CNT_ON];

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_bad_read;
        req.rd && req.bad_addr && en_r[4] |=> flags_r[4];
    endproperty
    a_bad_read: assert property (p_bad_read) else $error("bad read flag missing");

    property p_bad_write;
        req.wr && req.bad_addr && en_r[3] |=> flags_r[3];
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("bad write flag missing");

    property p_link_crc;
        link_crc_bad && en_r[2] |=> flags_r[2] && fault_flags[2];
    endproperty
    a_link_crc: assert property (p_link_crc) else $error("link crc flag missing");

    property p_cfg_quiet;
        !cfg_chk_on |=> !$rose(flags_r[1]);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("config crc flag without check");

    property p_rom_once;
        rom_chk |=> !rom_chk [*8];
    endproperty
    a_rom_once: assert property (p_rom_once) else $error("rom check repeated");

    property p_gate;
        $rose(flags_r[3]) |-> $past(en_r[3]);
    endproperty
    a_gate: assert property (p_gate) else $error("flag raised while disabled");

    property p_en_write;
        wr_en |=> en_r == ($past(req.wdata) & 16'h1FFF);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_ticks;
        en_r[12] ##1 en_r[12] |-> ticks_r == $past(ticks_r) + TICK_W'(1);
    endproperty
    a_ticks: assert property (p_ticks) else $error("tick counter stalled");

    property p_range_on;
        wr_en |=> pos_input_range_fault_on == $past(req.wdata[11])
                  && neg_input_range_fault_on == $past(req.wdata[10]);
    endproperty
    a_range_on: assert property (p_range_on) else $error("range enable mismatch");

    property p_w1c_hold;
        flags_r[4] && !(clr_flags && req.wdata[4]) |=> flags_r[4];
    endproperty
    a_w1c_hold: assert property (p_w1c_hold) else $error("flag dropped without clear");

    c_bad_read: cover property (req.rd && req.bad_addr && en_r[4] ##1 flags_r[4]);
    c_clear: cover property (flags_r[2] ##1 clr_flags && req.wdata[2] ##1 !flags_r[2]);
    c_cfg_crc: cover property ($rose(flags_r[1]));
    c_ticks: cover property (en_r[12] [*3]);

endmodule : fault_flag_bank

`default_nettype wire

// >>> dv/host_model.sv
// host side model that issues register requests and link CRC pulses
`timescale 1ns/1ns
`default_nettype none

module host_model (
    input wire logic ref_clk,
    output var fault_flag_bank_pkg::reg_req_t req,
    output logic link_crc_bad
);
    // ****************************************
    // request driver
    // ****************************************
    initial begin
        req = '0;
        link_crc_bad = 1'b0;
    end

    // one request held for one edge; rd and wr then drop to zero, the other fields show the inverse, not the last value
    task automatic access(input logic rd, input logic wr, input logic bad,
                          input logic [5:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        req <= '{rd: rd, wr: wr, bad_addr: bad, addr: addr, wdata: data};
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b0, bad_addr: ~bad, addr: ~addr, wdata: ~data};
    endtask : access

    task automatic crc_pulse();
        @(posedge ref_clk);
        link_crc_bad <= 1'b1;
        @(posedge ref_clk);
        link_crc_bad <= 1'b0;
    endtask : crc_pulse
endmodule : host_model

`default_nettype wire

// >>> dv/fault_flag_bank_tb.sv
// self-checking testbench of the fault flag bank
`timescale 1ns/1ns
`default_nettype none
`include "fault_flag_bank_defs.svh"

module fault_flag_bank_tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    fault_flag_bank_pkg::reg_req_t req;
    logic link_crc_bad;
    logic [7:0] cfg_image = 8'h3C;
    logic [7:0] rom_image = 8'h00;
    logic [15:0] rd_data, fault_flags, fault_flag_enables, d1, d2;
    logic pos_on, neg_on, tick_on;
    int err_count = 0;
    int comparisons = 0;

    always #5 ref_clk = ~ref_clk;

    host_model i_host (.ref_clk(ref_clk), .req(req), .link_crc_bad(link_crc_bad));

    // small period keeps the config check quick; rom of zeros never matches reference 0
    fault_flag_bank #(.CFG_W(8), .CHECK_PERIOD(4)) i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .req(req), .link_crc_bad(link_crc_bad),
        .cfg_image(cfg_image), .rom_image(rom_image), .rd_data(rd_data),
        .fault_flags(fault_flags), .fault_flag_enables(fault_flag_enables),
        .pos_input_range_fault_on(pos_on), .neg_input_range_fault_on(neg_on),
        .master_tick_counter_on(tick_on)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic bad, input logic [5:0] addr, output logic [15:0] data);
        i_host.access(1'b1, 1'b0, bad, addr, 16'h0000);
        @(posedge ref_clk);
        #1 data = rd_data;
    endtask : rd

    task automatic wr(input logic bad, input logic [5:0] addr, input logic [15:0] data);
        i_host.access(1'b0, 1'b1, bad, addr, data);
        @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        #1 chk(fault_flag_enables, 16'h0040);
        rd(1'b0, `FFB_ADDR_ENABLES, d1);
        chk(d1, 16'h0040);
        chk(fault_flags, 16'h0000);
        chk({13'h0, pos_on, neg_on, tick_on}, 16'h0000);
        $display("test reset done");
        // the bad read, bad write and link crc detectors fire while their enables are still clear
        rd(1'b1, 6'h2A, d1);
        wr(1'b1, 6'h2B, 16'h0000);
        i_host.crc_pulse();
        @(posedge ref_clk);
        #1 chk(fault_flags, 16'h0000);
        $display("test gating done");
        wr(1'b0, `FFB_ADDR_ENABLES, 16'hFFFF);
        chk(fault_flag_enables, 16'h1FFF);
        chk({13'h0, pos_on, neg_on, tick_on}, 16'h0007);
        repeat (2) @(posedge ref_clk);
        #1 chk(fault_flags, 16'h0001);
        rd(1'b0, `FFB_ADDR_TICKS, d1);
        rd(1'b0, `FFB_ADDR_TICKS, d2);
        chk(d2 - d1, 16'h0003);
        $display("test enables done");
        rd(1'b1, 6'h2A, d1);
        chk(d1, 16'h0000);
        chk(fault_flags, 16'h0011);
        wr(1'b1, `FFB_ADDR_ENABLES, 16'h0000);
        chk(fault_flags, 16'h0019);
        chk(fault_flag_enables, 16'h1FFF);
        i_host.crc_pulse();
        @(posedge ref_clk);
        #1 chk(fault_flags, 16'h001D);
        rd(1'b0, `FFB_ADDR_FLAGS, d1);
        chk(d1, 16'h001D);
        $display("test events done");
        wr(1'b0, `FFB_ADDR_FLAGS, 16'h0000);
        chk(fault_flags, 16'h001D);
        wr(1'b0, `FFB_ADDR_FLAGS, 16'h0004);
        chk(fault_flags, 16'h0019);
        wr(1'b0, `FFB_ADDR_FLAGS, 16'hFFFF);
        chk(fault_flags, 16'h0000);
        $display("test clear done");
        // quiet gap so the change is judged by checks with no write in between
        repeat (10) @(posedge ref_clk);
        cfg_image <= 8'hA5;
        repeat (12) @(posedge ref_clk);
        #1 chk(fault_flags, 16'h0002);
        $display("test config check done");
        conclude();
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        err_count++;
        conclude();
    end
endmodule : fault_flag_bank_tb

`default_nettype wire
